// ---- hdl/tmw_pkg.sv ----
// Package with register map, field layout, reset values and shared types of the test-mode/wake-up register slice.
package tmw_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [7:0] TMW_ADDR_TEST_SELECT_Y = 8'h0e;
  localparam logic [7:0] TMW_ADDR_TEST_PHASE_Z  = 8'h0f;
  localparam logic [7:0] TMW_ADDR_CONFIG        = 8'h10;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] TMW_RST_TEST_SELECT_Y = 8'h38;
  localparam logic [7:0] TMW_RST_TEST_PHASE_Z  = 8'h00;
  localparam logic [7:0] TMW_RST_CONFIG        = 8'h01;

  // ==========================================================================
  // Field positions shared by the two threshold registers.
  localparam int TMW_SEL_HI    = 7;
  localparam int TMW_SEL_LO    = 6;
  localparam int TMW_UPPER_HI  = 5;
  localparam int TMW_UPPER_LO  = 3;
  localparam int TMW_LOWER_HI  = 2;
  localparam int TMW_LOWER_LO  = 0;
  localparam int TMW_THR_LOW_W = 3;

  // Configuration register field positions.
  localparam int TMW_CFG_TEMP_DIS   = 7;
  localparam int TMW_CFG_ANGULAR    = 6;
  localparam int TMW_CFG_ADC_TRIGGER_OPTION_HI    = 5;
  localparam int TMW_CFG_ADC_TRIGGER_OPTION_LO    = 4;
  localparam int TMW_CFG_DOUBLE     = 3;
  localparam int TMW_CFG_TCOMP_HI   = 2;
  localparam int TMW_CFG_TCOMP_LO   = 1;
  localparam int TMW_CFG_PARITY_BIT = 0;

  // ==========================================================================
  // Test-select encodings.
  typedef enum logic [1:0] {
    TMW_TEST_NONE     = 2'b00,
    TMW_TEST_VOLTAGE  = 2'b01,
    TMW_TEST_SPIN     = 2'b10,
    TMW_TEST_DIGITAL  = 2'b11
  } tmw_test_e;

  // Register access request from the serial interface layer.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmw_req_s;

  // Decoded configuration fields handed to the measurement path.
  typedef struct packed {
    logic       temperature_disable;
    logic       angular_only_mode;
    logic [1:0] adc_trigger_option;
    logic       double_sensitivity;
    logic [1:0] magnet_temp_compensation;
  } tmw_cfg_s;

endpackage

// ---- hdl/tmw_regs.sv ----
// Test-select, test-phase, threshold low bits and configuration registers with wake-up compare.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1 - Test-select 00 means normal operation, no test runs and the test flag reads zero.
// R2 - Any non-zero test-select sets the test flag and routes the test result into the measurement data.
// R3 - Test-select 01 runs the bias and supply voltage test on all sensing plates and the supply.
// R4 - Test-select 10 runs the spin-switch and offset test on the channel chosen by the test-phase field.
// R5 - Test-select 11 runs the digital path test with patterns chosen by the test-phase field.
// R6 - The test-phase field is ignored in normal operation and in the voltage test.
// R7 - The Y upper low bits extend the Y upper threshold and a Y reading at or above it raises the interrupt.
// R8 - The Y lower low bits extend the Y lower threshold and a Y reading at or below it raises the interrupt.
// R9 - The Z upper low bits extend the Z upper threshold and a Z reading at or above it raises the interrupt.
// R10 - The Z lower low bits extend the Z lower threshold and a Z reading at or below it raises the interrupt.
// R11 - After reset the test-select and Y threshold register reads 38 hex.
// R12 - Wake-up only becomes active with tests off, odd configuration parity and the parity flag set.
// R13 - The parity bit gives odd parity over registers 07 to 10 without the wake-active, test-select and phase bits.
// R14 - Each full threshold joins its high-order bits with the three low bits and compares to the signed axis value.
module tmw_regs
  import tmw_pkg::*;
#(
  parameter int MEAS_W = 12,
  parameter int THR_HI_W = 8
) (
  input  wire logic                CORE_CLK_I,
  input  wire logic                RSTN_I,
  input  wire tmw_req_s            REQ_I,
  output logic [7:0]               RDATA_O,
  input  wire logic                OTHER_REGS_PARITY_I,
  input  wire logic                PARITY_UPDATE_I,
  input  wire logic                WAKE_ENABLE_I,
  input  wire logic                INT_MODE_I,
  input  wire logic [THR_HI_W-1:0] Y_UPPER_HI_I,
  input  wire logic [THR_HI_W-1:0] Y_LOWER_HI_I,
  input  wire logic [THR_HI_W-1:0] Z_UPPER_HI_I,
  input  wire logic [THR_HI_W-1:0] Z_LOWER_HI_I,
  input  wire logic                MEAS_VALID_I,
  input  wire logic [MEAS_W-1:0]   MEAS_Y_I,
  input  wire logic [MEAS_W-1:0]   MEAS_Z_I,
  input  wire logic [MEAS_W-1:0]   TEST_RESULT_I,
  input  wire logic [MEAS_W-1:0]   FIELD_RESULT_I,
  output logic [MEAS_W-1:0]        MEAS_DATA_O,
  output logic                     TEST_FLAG_O,
  output tmw_test_e                TEST_SELECT_O,
  output logic [1:0]               TEST_PHASE_SELECT_O,
  output tmw_cfg_s                 CFG_O,
  output logic                     CONFIG_PARITY_FLAG_O,
  output logic                     WAKE_ACTIVE_FLAG_O,
  output logic                     WAKE_INT_O
);

  localparam int THR_W = THR_HI_W + TMW_THR_LOW_W;
  // The threshold spans the high-order bits from the neighbouring registers plus the three low
  // bits held here, so by default it is one bit narrower than the reading.
  // The reading loses its least significant bit before the compare; a crossing by that bit alone
  // is not seen, which keeps the comparators at threshold width.
  // MEAS_W must stay at or above THR_W, otherwise the part-select of the reading runs off its bottom.

  // ==========================================================================
  // State.
  // Only three byte-wide registers live here; the other covered bytes arrive as ready-made inputs,
  // namely the threshold high-order bits and the parity of the remaining covered registers.
  // The three byte-wide registers change only on a write strobe, so the software view and the decoded view
  // never differ by more than the one cycle that a write needs to land.
  logic [7:0]        test_select_and_y_threshold_low;
  logic [7:0]        test_phase_and_z_threshold_low;
  logic [7:0]        sensor_configuration;
  logic              config_parity_flag;
  logic [7:0]        rdata;
  logic [MEAS_W-1:0] meas_data;
  logic              wake_int;
  logic [7:0]        next_test_select_and_y_threshold_low;
  logic [7:0]        next_test_phase_and_z_threshold_low;
  logic [7:0]        next_sensor_configuration;
  logic              next_config_parity_flag;
  logic [7:0]        next_rdata;
  logic [MEAS_W-1:0] next_meas_data;
  logic              next_wake_int;

  // Decoded fields.
  tmw_test_e         test_select;
  logic [1:0]        test_phase_raw;
  logic              test_flag;
  logic              phase_used;
  logic              parity_odd;
  logic              wake_active;
  logic signed [THR_W-1:0] y_upper;
  logic signed [THR_W-1:0] y_lower;
  logic signed [THR_W-1:0] z_upper;
  logic signed [THR_W-1:0] z_lower;
  logic signed [THR_W-1:0] y_meas;
  logic signed [THR_W-1:0] z_meas;
  logic              hit;

  // ==========================================================================
  // Field decode and wake-up compare.
  // Field decode; the selector is a two-bit code so every value is legal.
  assign test_select    = tmw_test_e'(test_select_and_y_threshold_low[TMW_SEL_HI:TMW_SEL_LO]);
  assign test_phase_raw = test_phase_and_z_threshold_low[TMW_SEL_HI:TMW_SEL_LO];
  assign test_flag      = (test_select != TMW_TEST_NONE);                   // [R1] [R2]
  // The phase field keeps its stored value in every mode and is only masked on the way out, so a
  // later switch into a spin or digital test picks it up again without a rewrite.
  // Phase only reaches the analog side in spin and digital tests.
  assign phase_used     = (test_select == TMW_TEST_SPIN) ||                 // [R4]
                          (test_select == TMW_TEST_DIGITAL);                // [R5] [R6]

  // Odd parity over the covered bits; selector and phase bits stay out so tests need no parity fix.
  assign parity_odd = OTHER_REGS_PARITY_I ^                                 // [R13]
                      (^test_select_and_y_threshold_low[TMW_UPPER_HI:TMW_LOWER_LO]) ^
                      (^test_phase_and_z_threshold_low[TMW_UPPER_HI:TMW_LOWER_LO]) ^
                      (^sensor_configuration);

  // Wake-up runs only with tests off and a good parity flag.
  assign wake_active = WAKE_ENABLE_I && !test_flag && config_parity_flag;  // [R12]

  // Full thresholds are high bits joined with the three low bits.
  assign y_upper = {Y_UPPER_HI_I, test_select_and_y_threshold_low[TMW_UPPER_HI:TMW_UPPER_LO]}; // [R7] [R14]
  assign y_lower = {Y_LOWER_HI_I, test_select_and_y_threshold_low[TMW_LOWER_HI:TMW_LOWER_LO]}; // [R8] [R14]
  assign z_upper = {Z_UPPER_HI_I, test_phase_and_z_threshold_low[TMW_UPPER_HI:TMW_UPPER_LO]};  // [R9] [R14]
  assign z_lower = {Z_LOWER_HI_I, test_phase_and_z_threshold_low[TMW_LOWER_HI:TMW_LOWER_LO]};  // [R10] [R14]
  // The thresholds cover the top bits of the signed reading.
  assign y_meas = MEAS_Y_I[MEAS_W-1 -: THR_W];                              // [R14]
  assign z_meas = MEAS_Z_I[MEAS_W-1 -: THR_W];                              // [R14]

  // Any crossing on either axis counts.
  // Both bounds are inclusive; software must keep each lower bound at least two below its upper bound,
  // otherwise every conversion counts as a crossing.
  assign hit = (y_meas >= y_upper) || (y_meas <= y_lower) ||                // [R7] [R8]
               (z_meas >= z_upper) || (z_meas <= z_lower);                  // [R9] [R10]

  // ==========================================================================
  // Next-state logic for registers, parity flag, read data and outputs.
  always_comb begin
    // Every next value defaults to its register, so only the strobed paths and the wake-up drop below change state.
    next_test_select_and_y_threshold_low = test_select_and_y_threshold_low;
    next_test_phase_and_z_threshold_low  = test_phase_and_z_threshold_low;
    next_sensor_configuration            = sensor_configuration;
    next_config_parity_flag              = config_parity_flag;
    next_rdata                           = rdata;
    next_meas_data                       = meas_data;
    next_wake_int                        = wake_int;
    // Writes land on the next edge; an unmapped address leaves every register untouched.
    if (REQ_I.wr) begin
      unique case (REQ_I.addr)
        TMW_ADDR_TEST_SELECT_Y: next_test_select_and_y_threshold_low = REQ_I.wdata;
        TMW_ADDR_TEST_PHASE_Z:  next_test_phase_and_z_threshold_low  = REQ_I.wdata;
        TMW_ADDR_CONFIG:        next_sensor_configuration            = REQ_I.wdata;
        default: ;
      endcase
    end
    // The flag is recomputed only on an update pulse, never on a write alone, so software sees
    // the old flag until the update that follows its write.
    // The flag takes the parity on the edge that ends an update pulse, not one cycle after a covered write.
    // A bad parity at that update drops the flag, which in turn stops wake-up.
    if (PARITY_UPDATE_I) begin
      next_config_parity_flag = parity_odd;                                 // [R13] [R12]
    end
    // Reads capture the current contents, so a read in the same cycle as a write returns the old
    // value; an unmapped address reads as zero.
    if (REQ_I.rd) begin
      unique case (REQ_I.addr)
        TMW_ADDR_TEST_SELECT_Y: next_rdata = test_select_and_y_threshold_low;
        TMW_ADDR_TEST_PHASE_Z:  next_rdata = test_phase_and_z_threshold_low;
        TMW_ADDR_CONFIG:        next_rdata = sensor_configuration;
        default:                next_rdata = 8'h00;
      endcase
    end
    // Test results replace field data while any test runs.
    // The choice follows the test flag at the conversion strobe, not at the time the word is read,
    // so a test switched on between conversions only shows with the next conversion.
    if (MEAS_VALID_I) begin
      next_meas_data = test_flag ? TEST_RESULT_I : FIELD_RESULT_I;          // [R2] [R3]
      next_wake_int  = wake_active && !INT_MODE_I && hit;                   // [R7] [R8] [R9] [R10]
    end
    // Losing the wake condition or setting the interrupt mode drops a pending interrupt on the
    // next edge, even without a new conversion.
    if (!wake_active || INT_MODE_I) begin
      next_wake_int = 1'b0;                                                 // [R12]
    end
  end

  // Register stage; the parity flag starts cleared so software must fix the parity once.
  // Reset loads constants only; read data and the measurement word clear too, so RDATA_O shows zero
  // after reset until the first read captures the contents of a register.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      test_select_and_y_threshold_low <= TMW_RST_TEST_SELECT_Y;            // [R11]
      test_phase_and_z_threshold_low  <= TMW_RST_TEST_PHASE_Z;
      sensor_configuration            <= TMW_RST_CONFIG;
      config_parity_flag              <= 1'b0;
      rdata                           <= 8'h00;
      meas_data                       <= '0;
      wake_int                        <= 1'b0;
    end else begin
      test_select_and_y_threshold_low <= next_test_select_and_y_threshold_low;
      test_phase_and_z_threshold_low  <= next_test_phase_and_z_threshold_low;
      sensor_configuration            <= next_sensor_configuration;
      config_parity_flag              <= next_config_parity_flag;
      rdata                           <= next_rdata;
      meas_data                       <= next_meas_data;
      wake_int                        <= next_wake_int;
    end
  end

  // ==========================================================================
  // Outputs.
  // Status outputs are decoded straight from the registers, so the measurement path sees a new
  // test or phase in the cycle after the write, with no extra pipeline stage.
  assign RDATA_O              = rdata;
  assign MEAS_DATA_O          = meas_data;
  assign TEST_FLAG_O          = test_flag;                                  // [R1]
  assign TEST_SELECT_O        = test_select;                                // [R3] [R4] [R5]
  assign TEST_PHASE_SELECT_O  = phase_used ? test_phase_raw : 2'b00;        // [R6]
  assign CONFIG_PARITY_FLAG_O = config_parity_flag;
  assign WAKE_ACTIVE_FLAG_O   = wake_active;                                // [R12]
  assign WAKE_INT_O           = wake_int;
  assign CFG_O.temperature_disable      = sensor_configuration[TMW_CFG_TEMP_DIS];
  assign CFG_O.angular_only_mode        = sensor_configuration[TMW_CFG_ANGULAR];
  assign CFG_O.adc_trigger_option       = sensor_configuration[TMW_CFG_ADC_TRIGGER_OPTION_HI:TMW_CFG_ADC_TRIGGER_OPTION_LO];
  assign CFG_O.double_sensitivity       = sensor_configuration[TMW_CFG_DOUBLE];
  assign CFG_O.magnet_temp_compensation = sensor_configuration[TMW_CFG_TCOMP_HI:TMW_CFG_TCOMP_LO];

endmodule

`default_nettype wire

// ---- testbench/tmw_regs_chk.sv ----
// Concurrent checks on the ports of the test-mode and wake-up register slice.
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Checker module.
module tmw_regs_chk
  import tmw_pkg::*;
#(
  parameter int MEAS_W = 12
) (
  input wire logic              CORE_CLK_I,
  input wire logic              RSTN_I,
  input wire tmw_req_s          REQ_I,
  input wire logic              PARITY_UPDATE_I,
  input wire logic              WAKE_ENABLE_I,
  input wire logic              INT_MODE_I,
  input wire logic              MEAS_VALID_I,
  input wire logic [MEAS_W-1:0] TEST_RESULT_I,
  input wire logic [MEAS_W-1:0] FIELD_RESULT_I,
  input wire logic [MEAS_W-1:0] MEAS_DATA_O,
  input wire logic              TEST_FLAG_O,
  input wire tmw_test_e         TEST_SELECT_O,
  input wire logic [1:0]        TEST_PHASE_SELECT_O,
  input wire logic              CONFIG_PARITY_FLAG_O,
  input wire logic              WAKE_ACTIVE_FLAG_O,
  input wire logic              WAKE_INT_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Reset cycles are masked, so a write caught by reset is never judged.
  a_sel_write: assert property (REQ_I.wr && REQ_I.addr == TMW_ADDR_TEST_SELECT_Y
    |=> TEST_SELECT_O == $past(REQ_I.wdata[7:6])) else $error("test select write lost");
  a_test_flag: assert property (TEST_FLAG_O == (TEST_SELECT_O != TMW_TEST_NONE))
    else $error("test flag disagrees with select");
  a_flag_write: assert property (REQ_I.wr && REQ_I.addr == TMW_ADDR_TEST_SELECT_Y
    |=> TEST_FLAG_O == ($past(REQ_I.wdata[7:6]) != 2'b00)) else $error("test flag not set by write");
  a_wake_drop: assert property (!WAKE_ACTIVE_FLAG_O |=> !WAKE_INT_O)
    else $error("interrupt without wake-up");
  a_phase_ignored: assert property (TEST_SELECT_O inside {TMW_TEST_NONE, TMW_TEST_VOLTAGE}
    |-> TEST_PHASE_SELECT_O == 2'b00) else $error("phase used outside spin or digital test");
  a_meas_test: assert property (MEAS_VALID_I && TEST_FLAG_O |=> MEAS_DATA_O == $past(TEST_RESULT_I))
    else $error("test result not routed");
  a_meas_field: assert property (MEAS_VALID_I && !TEST_FLAG_O |=> MEAS_DATA_O == $past(FIELD_RESULT_I))
    else $error("field result not routed");
  a_wake_gate: assert property (WAKE_ACTIVE_FLAG_O == (WAKE_ENABLE_I && !TEST_FLAG_O && CONFIG_PARITY_FLAG_O))
    else $error("wake active gating wrong");
  a_int_block: assert property (INT_MODE_I |=> !WAKE_INT_O) else $error("interrupt not blocked");
  a_parity_hold: assert property (!PARITY_UPDATE_I |=> $stable(CONFIG_PARITY_FLAG_O))
    else $error("parity flag moved without update");
  // Main scenarios.
  c_digital: cover property (TEST_SELECT_O == TMW_TEST_DIGITAL);
  c_wake_int: cover property ($rose(WAKE_INT_O));
  c_parity_set: cover property ($rose(CONFIG_PARITY_FLAG_O));
endmodule
bind tmw_regs tmw_regs_chk #(.MEAS_W(MEAS_W)) i_tmw_regs_chk (.*);
`default_nettype wire

// ---- testbench/tmw_host.sv ----
// Host model that issues register accesses to the slice.
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Host model.
module tmw_host
  import tmw_pkg::*;
(
  input  wire logic       CORE_CLK_I,
  input  wire logic [7:0] RDATA_O,
  output var  tmw_req_s   REQ_O
);
  initial REQ_O = '0;
  // Idle lines show the inverse of the last value, so stale data never looks like a request.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge CORE_CLK_I);
    REQ_O = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge CORE_CLK_I);
    REQ_O = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = RDATA_O;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_tmw_regs.sv ----
// Self-checking bench for the test-mode and wake-up register slice.
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Bench top.
module tb_tmw_regs;
  import tmw_pkg::*;
  logic        clk, rst_n, other, upd, wake_en, int_mode, mv, tflag, pflag, wact, wint;
  logic [7:0]  rdata, q, yu, yl, zu, zl;
  logic [11:0] my, mz, tres, fres, mdata;
  logic [1:0]  phase;
  tmw_test_e   tsel;
  tmw_cfg_s    cfg;
  tmw_req_s    req;
  int          num_errors, n_compared, cycles;
  logic [24:0] tbl [8] = '{{12'h10a, 12'h000, 1'b1}, {12'h108, 12'h000, 1'b0}, {12'hf04, 12'h000, 1'b1},
    {12'hf06, 12'h000, 1'b0}, {12'h000, 12'h086, 1'b1}, {12'h000, 12'h084, 1'b0}, {12'h000, 12'hf8c, 1'b1},
    {12'h000, 12'hf8e, 1'b0}};
  logic [7:0]  cfgv [2] = '{8'h6c, 8'hd3};
  tmw_host i_tmw_host (.CORE_CLK_I(clk), .RDATA_O(rdata), .REQ_O(req));
  tmw_regs i_tmw_regs (.CORE_CLK_I(clk), .RSTN_I(rst_n), .REQ_I(req), .RDATA_O(rdata),
    .OTHER_REGS_PARITY_I(other), .PARITY_UPDATE_I(upd), .WAKE_ENABLE_I(wake_en), .INT_MODE_I(int_mode),
    .Y_UPPER_HI_I(yu), .Y_LOWER_HI_I(yl), .Z_UPPER_HI_I(zu), .Z_LOWER_HI_I(zl), .MEAS_VALID_I(mv),
    .MEAS_Y_I(my), .MEAS_Z_I(mz), .TEST_RESULT_I(tres), .FIELD_RESULT_I(fres), .MEAS_DATA_O(mdata),
    .TEST_FLAG_O(tflag), .TEST_SELECT_O(tsel), .TEST_PHASE_SELECT_O(phase), .CFG_O(cfg),
    .CONFIG_PARITY_FLAG_O(pflag), .WAKE_ACTIVE_FLAG_O(wact), .WAKE_INT_O(wint));
  // Free-running clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // A hang is cut short well beyond the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_tmw_host.access(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    i_tmw_host.access(1'b0, a, 8'h00, q);
    chk("read data", e, q);
  endtask
  // Pulses span one rising edge and the result is looked at on the next falling edge.
  task automatic pulse(input logic m, input logic [11:0] y, input logic [11:0] z);
    @(negedge clk) {mv, upd, my, mz} = {m, !m, y, z};
    @(negedge clk) {mv, upd} = 2'b00;
  endtask
  // Main sequence.
  initial begin
    {rst_n, other, upd, wake_en, int_mode, mv} = 6'b010000;
    {yu, yl, zu, zl, my, mz, tres, fres} = {32'h10f008f8, 24'h000000, 24'h5a53c3};
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rdc(8'h0e, 8'h38);
    rdc(8'h0f, 8'h00);
    rdc(8'h10, 8'h01);
    rdc(8'h11, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(8'h0e, {s[1:0], 6'h2a});
      wr(8'h0f, 8'hde);
      chk("test flag", s != 0, tflag);
      chk("test select", s[1:0], tsel);
      chk("test phase", (s > 1) ? 2'b11 : 2'b00, phase);
      pulse(1'b1, 12'h000, 12'h000);
      chk("meas data", (s != 0) ? tres : fres, mdata);
      rdc(8'h0e, {s[1:0], 6'h2a});
    end
    wr(8'h0e, 8'h2a);
    wake_en = 1'b1;
    foreach (cfgv[i]) begin
      wr(8'h10, cfgv[i]);
      pulse(1'b0, 12'h000, 12'h000);
      chk("parity flag", ^{other, 6'h2a, 6'h1e, cfgv[i]}, pflag);
      chk("wake active", ^{other, 6'h2a, 6'h1e, cfgv[i]}, wact);
      chk("config", cfgv[i][7:1], cfg);
    end
    foreach (tbl[i]) begin
      pulse(1'b1, tbl[i][24:13], tbl[i][12:1]);
      chk("wake int", tbl[i][0], wint);
    end
    int_mode = 1'b1;
    pulse(1'b1, 12'h10a, 12'h000);
    chk("wake int", 1'b0, wint);
    wr(8'h0e, 8'hea);
    pulse(1'b0, 12'h000, 12'h000);
    chk("parity flag", 1'b1, pflag);
    chk("wake active", 1'b0, wact);
    complete_run();
  end
endmodule
`default_nettype wire
